// ===== hdl/wdtu_pkg.sv
// Shared constants for the watchdog timer unit: bus map, field positions,
// reset values and clock ratios.
// Assumes a 100 MHz system clock and a nominal 32 kHz watchdog time base.
package wdtu_pkg;

  // System clock and the low-power RC time base derived from it
  localparam int CLK_HZ       = 100_000_000;
  localparam int RC_OSC_HZ    = 32_000;
  localparam int RC_OSC_DIV   = CLK_HZ / RC_OSC_HZ;

  // Prescaler ratios and counter widths
  localparam int PRE_SHORT    = 32;
  localparam int PRE_LONG     = 128;
  localparam int PRE_SH_SHORT = 5;
  localparam int PRE_SH_LONG  = 7;
  localparam int PRE_W        = 7;
  localparam int POST_W       = 16;
  localparam int SEL_W        = 4;
  localparam int ELAPSED_W    = 24;

  // Register byte addresses
  localparam logic [7:0] OFS_RCTL     = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  // Reset control register fields
  localparam int RCTL_IDLE     = 2;
  localparam int RCTL_SLEEP    = 3;
  localparam int RCTL_TIMEOUT  = 4;
  localparam int RCTL_SOFT_EN  = 5;

  // Configuration word fields
  localparam int CFG_POST_LSB  = 0;
  localparam int CFG_PRESCALE  = 4;
  localparam int CFG_WIN_DIS   = 6;
  localparam int CFG_FORCED    = 7;
  localparam logic [7:0] CFG_RST = 8'h5f;

  // Interrupt status and mask fields
  localparam int IRQ_TIMEOUT   = 0;
  localparam int IRQ_WINDOW    = 1;
  localparam int IRQ_WAKE      = 2;
  localparam int IRQ_W         = 3;

  typedef enum logic [1:0] {
    WDTU_RUN,
    WDTU_SLEEP,
    WDTU_IDLE
  } wdtu_mode_e;

endpackage

// ===== hdl/wdtu_tick_div.sv
// Clock-enable divider: one-cycle tick every DIV cycles while running.
// Assumes run_in and clear_in come from logic on the same clock.
module wdtu_tick_div #(
  parameter int DIV = wdtu_pkg::RC_OSC_DIV
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic run_in,
  input  wire logic clear_in,
  output logic      tick_out
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (clear_in || !run_in) begin
      next_cnt = '0;
    end else if (cnt == CW'(DIV - 1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

endmodule

// ===== hdl/wdtu_scaler.sv
// Prescaler and postscaler chain of the watchdog, plus window detection.
// Assumes tick_in is a one-cycle pulse at the watchdog time-base rate.
module wdtu_scaler (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       tick_in,
  input  wire logic                       clear_in,
  input  wire logic                       long_pre_in,
  input  wire logic [wdtu_pkg::SEL_W-1:0] post_sel_in,
  output logic                            timeout_out,
  output logic                            window_open_out,
  output logic [wdtu_pkg::ELAPSED_W-1:0]  elapsed_out
);

  logic [wdtu_pkg::PRE_W-1:0]  pre_cnt;
  logic [wdtu_pkg::PRE_W-1:0]  next_pre_cnt;
  logic [wdtu_pkg::POST_W-1:0] post_cnt;
  logic [wdtu_pkg::POST_W-1:0] next_post_cnt;
  logic                        next_timeout;
  logic [wdtu_pkg::PRE_W-1:0]  pre_last;
  logic [wdtu_pkg::POST_W-1:0] post_last;
  logic [4:0]                  total_sh;
  logic [wdtu_pkg::ELAPSED_W:0] total;

  // Prescaler: 1:128 when set, 1:32 when clear
  assign pre_last  = long_pre_in ? wdtu_pkg::PRE_W'(wdtu_pkg::PRE_LONG - 1)
                                 : wdtu_pkg::PRE_W'(wdtu_pkg::PRE_SHORT - 1);
  // Postscaler ratio is 2 to the power of the select, 1:1 .. 1:32768
  assign post_last = wdtu_pkg::POST_W'((32'h1 << post_sel_in) - 1);
  assign total_sh  = 5'(post_sel_in) + (long_pre_in ?
                     5'(wdtu_pkg::PRE_SH_LONG) : 5'(wdtu_pkg::PRE_SH_SHORT));
  assign total     = (wdtu_pkg::ELAPSED_W+1)'(1) << total_sh;

  always_comb begin
    next_pre_cnt  = pre_cnt;
    next_post_cnt = post_cnt;
    next_timeout  = 1'b0;
    if (clear_in) begin
      next_pre_cnt  = '0;
      next_post_cnt = '0;
    end else if (tick_in) begin
      if (pre_cnt >= pre_last) begin
        next_pre_cnt = '0;
        if (post_cnt >= post_last) begin
          next_post_cnt = '0;
          next_timeout  = 1'b1;
        end else begin
          next_post_cnt = post_cnt + 1'b1;
        end
      end else begin
        next_pre_cnt = pre_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_cnt     <= '0;
      post_cnt    <= '0;
      timeout_out <= 1'b0;
    end else begin
      pre_cnt     <= next_pre_cnt;
      post_cnt    <= next_post_cnt;
      timeout_out <= next_timeout;
    end
  end

  // Time-base ticks since the last clear
  assign elapsed_out = long_pre_in ?
    wdtu_pkg::ELAPSED_W'({post_cnt, pre_cnt}) :
    wdtu_pkg::ELAPSED_W'({post_cnt, pre_cnt[4:0]});

  // Last quarter of the period: elapsed >= total - total/4
  assign window_open_out = ((wdtu_pkg::ELAPSED_W+1)'(elapsed_out) << 2)
                           >= (total << 1) + total;

endmodule

// ===== hdl/wdtu_watchdog.sv
// Watchdog timer unit: configuration and reset-control registers on a
// classic Wishbone slave, power-save tracking, window check, reset and
// wake generation, sticky interrupt status with mask.
// Assumes core strobes (clear, power save, clock switch, wake) are
// one-cycle pulses on clk_in; rst_b_in is the device reset.
//
// What this block does
// - Watchdog counts on the low-power RC base; enabling it starts that.
// - The time base is a nominal 32 kHz.
// - Prescaler divides by 32 or by 128 per the prescale select.
// - Prescaler alone gives 1 ms (divide 32) or 4 ms (divide 128).
// - A 4-bit postscaler select gives sixteen ratios, 1:1 to 1:32768.
// - Counters clear on reset, clock switch, sleep entry/exit and clear.
// - An enabled watchdog keeps counting in sleep and idle.
// - Timeout in sleep or idle wakes the core after its power-save step.
// - Forced enable keeps the watchdog on whatever the soft enable bit holds.
// - Without forced enable it runs only while soft enable is set.
// - Every device reset clears the soft enable bit.
// - In window mode an early clear instruction causes a watchdog reset.
// - Timeout flag stays set until software clears it.
// - Prescale select one means 1:128, zero means 1:32.
// - Window disable one means normal mode, zero means window mode.
//
// The Wishbone slave port and the address map are this design's own decisions.
module wdtu_watchdog (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Wishbone classic slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Core events
  input  wire logic        clear_instruction_in,
  input  wire logic        power_save_instruction_in,
  input  wire logic        power_save_sleep_in,
  input  wire logic        clock_switch_done_in,
  input  wire logic        other_wake_in,
  // Results
  output logic             low_power_rc_osc_en_out,
  output logic             watchdog_reset_out,
  output logic             wake_out,
  output logic             irq_out
);

  // Registers
  logic                         soft_enable;
  logic                         next_soft_enable;
  logic                         timeout_flag;
  logic                         next_timeout_flag;
  logic                         sleep_flag;
  logic                         next_sleep_flag;
  logic                         idle_flag;
  logic                         next_idle_flag;
  logic [7:0]                   cfg;
  logic [7:0]                   next_cfg;
  logic [wdtu_pkg::IRQ_W-1:0]   irq_stat;
  logic [wdtu_pkg::IRQ_W-1:0]   next_irq_stat;
  logic [wdtu_pkg::IRQ_W-1:0]   irq_mask;
  logic [wdtu_pkg::IRQ_W-1:0]   next_irq_mask;

  // Bus
  logic                         bus_req;
  logic                         bus_wr;
  logic [7:0]                   wbyte;
  logic [31:0]                  next_rdata;

  // Mode and events
  wdtu_pkg::wdtu_mode_e         mode;
  wdtu_pkg::wdtu_mode_e         next_mode;
  logic                         enable;
  logic                         window_mode;
  logic                         enter_lp;
  logic                         exit_lp;
  logic                         fire_reset;
  logic                         win_viol;
  logic                         clr_ok;
  logic                         do_wake;
  logic                         cnt_clear;
  logic                         next_osc_en;

  // Scaler signals
  logic                         rc_tick;
  logic                         tmo;
  logic                         window_open;
  logic [wdtu_pkg::ELAPSED_W-1:0] elapsed;

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr  = bus_req && wb_we_in && wb_sel_in[0];
  assign wbyte   = wb_dat_in[7:0];

  // Forced enable overrides the soft enable bit
  assign enable      = cfg[wdtu_pkg::CFG_FORCED] || soft_enable;
  // Window mode while window disable is clear
  assign window_mode = !cfg[wdtu_pkg::CFG_WIN_DIS];

  // Mode tracking and reset / wake decisions
  always_comb begin
    next_mode  = mode;
    enter_lp   = 1'b0;
    exit_lp    = 1'b0;
    fire_reset = 1'b0;
    win_viol   = 1'b0;
    clr_ok     = 1'b0;
    do_wake    = 1'b0;
    unique case (mode)
      wdtu_pkg::WDTU_RUN: begin
        if (tmo) begin
          fire_reset = 1'b1;
        end else if (clear_instruction_in && enable && window_mode &&
                     !window_open) begin
          win_viol   = 1'b1;
          fire_reset = 1'b1;
        end else if (clear_instruction_in) begin
          clr_ok = 1'b1;
        end else if (power_save_instruction_in) begin
          enter_lp  = 1'b1;
          next_mode = power_save_sleep_in ? wdtu_pkg::WDTU_SLEEP
                                          : wdtu_pkg::WDTU_IDLE;
        end
      end
      wdtu_pkg::WDTU_SLEEP, wdtu_pkg::WDTU_IDLE: begin
        // Counting goes on here; a timeout only wakes
        if (tmo) begin
          do_wake   = 1'b1;
          exit_lp   = 1'b1;
          next_mode = wdtu_pkg::WDTU_RUN;
        end else if (other_wake_in) begin
          exit_lp   = 1'b1;
          next_mode = wdtu_pkg::WDTU_RUN;
        end
      end
      default: begin
        next_mode = wdtu_pkg::WDTU_RUN;
      end
    endcase
  end

  // Any of these restarts prescaler and postscaler
  assign cnt_clear = !enable || clock_switch_done_in || enter_lp ||
                     exit_lp || clr_ok || fire_reset;

  // Time base runs only while the watchdog is enabled
  wdtu_tick_div #(
    .DIV (wdtu_pkg::RC_OSC_DIV)
  ) u_rc_osc (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .run_in   (enable),
    .clear_in (cnt_clear),
    .tick_out (rc_tick)
  );

  wdtu_scaler u_scaler (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .tick_in         (rc_tick),
    .clear_in        (cnt_clear),
    .long_pre_in     (cfg[wdtu_pkg::CFG_PRESCALE]),
    .post_sel_in     (cfg[wdtu_pkg::CFG_POST_LSB +: wdtu_pkg::SEL_W]),
    .timeout_out     (tmo),
    .window_open_out (window_open),
    .elapsed_out     (elapsed)
  );

  // Register updates; a hardware set wins over a same-cycle clear
  always_comb begin
    next_soft_enable  = soft_enable;
    next_timeout_flag = timeout_flag;
    next_sleep_flag   = sleep_flag;
    next_idle_flag    = idle_flag;
    next_cfg          = cfg;
    next_irq_stat     = irq_stat;
    next_irq_mask     = irq_mask;
    if (bus_wr) begin
      unique case (wb_adr_in)
        wdtu_pkg::OFS_RCTL: begin
          next_soft_enable = wbyte[wdtu_pkg::RCTL_SOFT_EN];
          if (wbyte[wdtu_pkg::RCTL_TIMEOUT]) begin
            next_timeout_flag = 1'b0;
          end
          if (wbyte[wdtu_pkg::RCTL_SLEEP]) begin
            next_sleep_flag = 1'b0;
          end
          if (wbyte[wdtu_pkg::RCTL_IDLE]) begin
            next_idle_flag = 1'b0;
          end
        end
        wdtu_pkg::OFS_CFG: begin
          next_cfg = wbyte;
        end
        wdtu_pkg::OFS_IRQ_STAT: begin
          next_irq_stat = irq_stat & ~wbyte[wdtu_pkg::IRQ_W-1:0];
        end
        wdtu_pkg::OFS_IRQ_MASK: begin
          next_irq_mask = wbyte[wdtu_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // A watchdog reset is a device reset for the soft enable
    if (fire_reset) begin
      next_soft_enable = 1'b0;
    end
    // Flag is sticky until software clears it
    if (tmo || win_viol) begin
      next_timeout_flag = 1'b1;
    end
    if (enter_lp && power_save_sleep_in) begin
      next_sleep_flag = 1'b1;
    end
    if (enter_lp && !power_save_sleep_in) begin
      next_idle_flag = 1'b1;
    end
    if (tmo) begin
      next_irq_stat[wdtu_pkg::IRQ_TIMEOUT] = 1'b1;
    end
    if (win_viol) begin
      next_irq_stat[wdtu_pkg::IRQ_WINDOW] = 1'b1;
    end
    if (do_wake) begin
      next_irq_stat[wdtu_pkg::IRQ_WAKE] = 1'b1;
    end
  end

  // Read data and acknowledge
  always_comb begin
    next_rdata = 32'h0;
    if (bus_req && !wb_we_in) begin
      unique case (wb_adr_in)
        wdtu_pkg::OFS_RCTL: begin
          next_rdata[wdtu_pkg::RCTL_SOFT_EN] = soft_enable;
          next_rdata[wdtu_pkg::RCTL_TIMEOUT] = timeout_flag;
          next_rdata[wdtu_pkg::RCTL_SLEEP]   = sleep_flag;
          next_rdata[wdtu_pkg::RCTL_IDLE]    = idle_flag;
        end
        wdtu_pkg::OFS_CFG: begin
          next_rdata[7:0] = cfg;
        end
        wdtu_pkg::OFS_IRQ_STAT: begin
          next_rdata[wdtu_pkg::IRQ_W-1:0] = irq_stat;
        end
        wdtu_pkg::OFS_IRQ_MASK: begin
          next_rdata[wdtu_pkg::IRQ_W-1:0] = irq_mask;
        end
        wdtu_pkg::OFS_STATUS: begin
          next_rdata[0]     = enable;
          next_rdata[2:1]   = mode;
          next_rdata[3]     = window_open;
          next_rdata[31:8]  = elapsed;
        end
        default: begin
        end
      endcase
    end
  end

  assign next_osc_en = enable;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_enable  <= 1'b0;
      timeout_flag <= 1'b0;
      sleep_flag   <= 1'b0;
      idle_flag    <= 1'b0;
      cfg          <= wdtu_pkg::CFG_RST;
      irq_stat     <= '0;
      irq_mask     <= '0;
    end else begin
      soft_enable  <= next_soft_enable;
      timeout_flag <= next_timeout_flag;
      sleep_flag   <= next_sleep_flag;
      idle_flag    <= next_idle_flag;
      cfg          <= next_cfg;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode                    <= wdtu_pkg::WDTU_RUN;
      wb_ack_out              <= 1'b0;
      wb_dat_out              <= 32'h0;
      low_power_rc_osc_en_out <= 1'b0;
      watchdog_reset_out      <= 1'b0;
      wake_out                <= 1'b0;
      irq_out                 <= 1'b0;
    end else begin
      mode                    <= next_mode;
      wb_ack_out              <= bus_req;
      wb_dat_out              <= next_rdata;
      low_power_rc_osc_en_out <= next_osc_en;
      watchdog_reset_out      <= fire_reset;
      wake_out                <= do_wake;
      irq_out                 <= |(next_irq_stat & next_irq_mask);
    end
  end

endmodule

// ===== verification/wdtu_watchdog_monitor.sv
// Port-level checker for the watchdog timer unit, bound to its top module.
// Assumes the fixed 3125-cycle tick, so no timeout comes before 32 ticks.
module wdtu_watchdog_monitor (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        clear_instruction_in,
  input wire logic        power_save_instruction_in,
  input wire logic        clock_switch_done_in,
  input wire logic        other_wake_in,
  input wire logic        low_power_rc_osc_en_out,
  input wire logic        watchdog_reset_out,
  input wire logic        wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_PERIOD = 96000;
  logic [31:0] since_clr;
  logic [31:0] next_since_clr;
  logic        low_pwr;
  logic        next_low_pwr;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Cycles since the counters were last cleared, as seen at the ports
  always_comb begin
    next_low_pwr   = low_pwr;
    next_since_clr = since_clr + 32'h1;
    if (!low_pwr && (clear_instruction_in || power_save_instruction_in))
      next_since_clr = 32'h0;
    if (!low_pwr && power_save_instruction_in)
      next_low_pwr = 1'b1;
    if (clock_switch_done_in || other_wake_in || wake_out ||
        watchdog_reset_out)
      next_since_clr = 32'h0;
    if (other_wake_in || wake_out || watchdog_reset_out)
      next_low_pwr = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_clr <= 32'h0;
      low_pwr   <= 1'b0;
    end else begin
      since_clr <= next_since_clr;
      low_pwr   <= next_low_pwr;
    end
  end

  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  a_ack_one_pulse: assert property (s_taken |=> s_ack_pulse)
    else $error("bus ack not a single pulse after request");
  a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  a_osc_off_start: assert property ($rose(rst_b_in) |->
    !low_power_rc_osc_en_out) else $error("watchdog on after reset");
  a_reset_needs_en: assert property (watchdog_reset_out |->
    low_power_rc_osc_en_out || $past(low_power_rc_osc_en_out))
    else $error("watchdog reset while disabled");
  a_wake_needs_en: assert property (wake_out |->
    low_power_rc_osc_en_out || $past(low_power_rc_osc_en_out))
    else $error("watchdog wake while disabled");
  a_pulses_exclusive: assert property (
    !(watchdog_reset_out && wake_out))
    else $error("reset and wake together");
  a_wake_single: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  a_wake_low_power: assert property (wake_out |-> low_pwr)
    else $error("wake outside low power");
  a_timeout_not_early: assert property ((wake_out ||
    (watchdog_reset_out && !$past(clear_instruction_in))) |->
    since_clr >= MIN_PERIOD) else $error("timeout before period");
endmodule

bind wdtu_watchdog wdtu_watchdog_monitor i_mon (.clk_in, .rst_b_in,
  .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out,
  .clear_instruction_in, .power_save_instruction_in,
  .clock_switch_done_in, .other_wake_in, .low_power_rc_osc_en_out,
  .watchdog_reset_out, .wake_out);

// ===== verification/wdtu_core_model.sv
// Model of the processor core: issues clear, power-save, clock switch
// and other wake strobes as one-cycle pulses; counts watchdog wakes.
// Assumes tasks are entered just after a rising edge of clk_in.
module wdtu_core_model (
  input  wire logic clk_in,
  input  wire logic wake_in,
  output logic      clear_out,
  output logic      psave_out,
  output logic      sleep_out,
  output logic      switch_out,
  output logic      other_wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wakes;

  initial begin
    clear_out      = 1'b0;
    psave_out      = 1'b0;
    sleep_out      = 1'b0;
    switch_out     = 1'b0;
    other_wake_out = 1'b0;
    wakes          = 0;
  end

  // Kinds: 0 clear, 1 idle, 2 sleep, 3 clock switch, 4 other wake
  // Clears come only when the bench asks, so window timing is its own
  task automatic pulse(input int kind);
    clear_out      <= (kind == 0);
    psave_out      <= (kind == 1 || kind == 2);
    sleep_out      <= (kind == 2);
    switch_out     <= (kind == 3);
    other_wake_out <= (kind == 4);
    @(posedge clk_in);
    clear_out      <= 1'b0;
    psave_out      <= 1'b0;
    switch_out     <= 1'b0;
    other_wake_out <= 1'b0;
  endtask

  // Resumes after the power-save step; flags are cleared by software
  always @(posedge clk_in) begin
    if (wake_in === 1'b1)
      wakes <= wakes + 1;
  end
endmodule

// ===== verification/watchdog_timer_unit_tb.sv
// Self-checking bench for the watchdog timer unit over classic Wishbone.
// Assumes the fixed 3125-cycle tick, so the shortest period is 100000.
module watchdog_timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        rst_b_in;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [3:0]  byte_en;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic        wb_ack;
  logic        clr, psave, psleep, cswitch, owake;
  logic        osc_en, wd_rst, wake, irq;
  int          err_total, checks_done, resets_seen, n;

  wdtu_watchdog i_wdtu_watchdog (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .clear_instruction_in(clr), .power_save_instruction_in(psave),
    .power_save_sleep_in(psleep), .clock_switch_done_in(cswitch),
    .other_wake_in(owake), .low_power_rc_osc_en_out(osc_en),
    .watchdog_reset_out(wd_rst), .wake_out(wake), .irq_out(irq));

  wdtu_core_model i_core (.clk_in(clk_in), .wake_in(wake),
    .clear_out(clr), .psave_out(psave), .sleep_out(psleep),
    .switch_out(cswitch), .other_wake_out(owake));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (wd_rst === 1'b1)
      resets_seen++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= {24'h0, d};
    wb_sel  <= byte_en;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      summarize();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    check(what, exp, rd);
  endtask

  initial begin
    rst_b_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    byte_en = 4'h1;
    wb_wdat = 32'h0;
    err_total = 0;
    checks_done = 0;
    resets_seen = 0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd_chk("cfg", wdtu_pkg::OFS_CFG, {24'h0, wdtu_pkg::CFG_RST});
    rd_chk("rctl", wdtu_pkg::OFS_RCTL, 32'h0);
    rd_chk("mask", wdtu_pkg::OFS_IRQ_MASK, 32'h0);
    byte_en = 4'he;
    wb(1'b1, wdtu_pkg::OFS_IRQ_MASK, 8'h07);
    byte_en = 4'h1;
    rd_chk("sel off", wdtu_pkg::OFS_IRQ_MASK, 32'h0);
    wb(1'b1, 8'h40, 8'hff);
    rd_chk("unmapped", 8'h40, 32'h0);
    check("osc off", 32'h0, {31'h0, osc_en});
    wb(1'b1, wdtu_pkg::OFS_CFG, 8'hc0);
    @(posedge clk_in);
    check("osc forced", 32'h1, {31'h0, osc_en});
    repeat (3200) @(posedge clk_in);
    wb(1'b0, wdtu_pkg::OFS_STATUS, 8'h00);
    check("ticks", 32'h1, {8'h0, rd[31:8]});
    i_core.pulse(3);
    rd_chk("after switch", wdtu_pkg::OFS_STATUS, 32'h1);
    repeat (3200) @(posedge clk_in);
    i_core.pulse(0);
    rd_chk("after clear", wdtu_pkg::OFS_STATUS, 32'h1);
    i_core.pulse(1);
    wb(1'b0, wdtu_pkg::OFS_STATUS, 8'h00);
    check("idle mode", 32'h5, {29'h0, rd[2:0]});
    rd_chk("idle flag", wdtu_pkg::OFS_RCTL, 32'h04);
    i_core.pulse(4);
    rd_chk("woken", wdtu_pkg::OFS_STATUS, 32'h1);
    wb(1'b1, wdtu_pkg::OFS_RCTL, 8'h04);
    rd_chk("idle clr", wdtu_pkg::OFS_RCTL, 32'h0);
    i_core.pulse(2);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wake !== 1'b1 && n < 110000);
    if (n >= 110000) begin
      err_total++;
      summarize();
    end
    @(posedge clk_in);
    check("wake time", 32'h1, {31'h0, n >= 96000 && n <= 104000});
    check("wakes", 32'h1, i_core.wakes);
    check("no reset", 32'h0, resets_seen);
    rd_chk("sleep flags", wdtu_pkg::OFS_RCTL, 32'h18);
    rd_chk("wake irq", wdtu_pkg::OFS_IRQ_STAT, 32'h05);
    wb(1'b1, wdtu_pkg::OFS_RCTL, 8'h18);
    wb(1'b1, wdtu_pkg::OFS_IRQ_STAT, 8'h07);
    rd_chk("flags clr", wdtu_pkg::OFS_RCTL, 32'h0);
    wb(1'b1, wdtu_pkg::OFS_CFG, 8'h00);
    @(posedge clk_in);
    check("osc soft off", 32'h0, {31'h0, osc_en});
    wb(1'b1, wdtu_pkg::OFS_IRQ_MASK, 8'h02);
    wb(1'b1, wdtu_pkg::OFS_RCTL, 8'h20);
    @(posedge clk_in);
    check("osc soft on", 32'h1, {31'h0, osc_en});
    i_core.pulse(0);
    repeat (3) @(posedge clk_in);
    check("early clear", 32'h1, resets_seen);
    check("irq on", 32'h1, {31'h0, irq});
    rd_chk("rctl after", wdtu_pkg::OFS_RCTL, 32'h10);
    rd_chk("win irq", wdtu_pkg::OFS_IRQ_STAT, 32'h02);
    wb(1'b1, wdtu_pkg::OFS_IRQ_MASK, 8'h00);
    @(posedge clk_in);
    check("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, wdtu_pkg::OFS_IRQ_MASK, 8'h02);
    @(posedge clk_in);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wb(1'b1, wdtu_pkg::OFS_IRQ_STAT, 8'h02);
    @(posedge clk_in);
    check("irq cleared", 32'h0, {31'h0, irq});
    summarize();
  end
endmodule
